// File: shared/utmsg_pkg.sv
// Purpose: Shared constants and carriers for the upstream training generator
// Assumes: One symbol-rate clock domain
// Notes:   Octet fields are packed least significant bit first
package utmsg_pkg;
  localparam int          BITS_W     = 4;
  localparam int          GAIN_W     = 12;
  localparam int          CNT_W      = 12;
  localparam int          OCT_W      = 8;
  localparam int          TONE_W     = 12;
  localparam int          PRBS_W     = 11;
  localparam int          MAX_GROUP  = 256;
  localparam int          SYNC_SYMS  = 15;
  localparam int          SYNC_SEG   = 5;
  localparam int          TONE_CYCLE = 10;
  localparam int          DEAD_STEP  = 5;
  // Field widths pushed into the octet packer
  localparam logic [4:0]  W_OCT      = 5'h08;
  localparam logic [4:0]  W_GAIN     = 5'h0c;
  localparam logic [4:0]  W_WORD     = 5'h10;
  localparam logic [3:0]  PILOT_BITS = 4'h2;
  localparam logic [11:0] PILOT_GAIN = 12'h000;
  localparam logic [1:0]  PT_ZERO    = 2'h0;
  localparam logic [1:0]  PT_ONE     = 2'h3;
  // Generator seed and taps; values arbitrary
  localparam logic [10:0] PRBS_SEED  = 11'h7ff;
  localparam int          PRBS_TAP_A = 10;
  localparam int          PRBS_TAP_B = 8;
  // Message descriptor of the bits-and-gains message; value arbitrary
  localparam logic [7:0]  BG_DESC    = 8'h00;

  typedef struct packed {
    logic                used;
    logic                pilot;
    logic                last;
    logic [BITS_W-1:0]   bits;
    logic [GAIN_W-1:0]   gain;
    logic [CNT_W-1:0]    count;
  } utmsg_item_s;

  typedef struct packed {
    logic [TONE_W-1:0]   idx;
    logic [1:0]          raw;
    logic [1:0]          point;
    logic                active;
  } utmsg_tone_s;
endpackage : utmsg_pkg

// File: src/utmsg_tone_mapper.sv
// Purpose: Picks the 4QAM point of one tone and applies the quarter-turn rotation
// Assumes: Purely combinational, registered by the caller
// Notes:   Points are Gray-ordered round the circle so rotation is an add
`timescale 1ns/100ps
module utmsg_tone_mapper (
  input  wire logic [utmsg_pkg::TONE_W-1:0] tone_idx,
  input  wire logic                         sync_mode,
  input  wire logic [1:0]                   sync_point,
  input  wire logic [15:0]                  msg,
  input  wire logic [1:0]                   rot,
  output logic      [1:0]                   raw,
  output logic      [1:0]                   point
);
  logic [3:0] r;
  logic [3:0] k;
  logic [1:0] q;

  // Message pair from the tone position inside each run of ten
  always_comb begin
    r = 4'(tone_idx % utmsg_pkg::TONE_CYCLE);
    k = (r < 4'h5) ? r - 4'h1 : r - 4'h2;
    if (sync_mode) begin
      raw = sync_point;
    end else if ((r % 4'(utmsg_pkg::DEAD_STEP)) == 4'h0) begin
      raw = utmsg_pkg::PT_ZERO;
    end else begin
      raw = {msg[{k[2:0], 1'b1}], msg[{k[2:0], 1'b0}]};
    end
  end

  // Gray to quadrant, add turns, back to Gray
  always_comb begin
    q     = {raw[1], raw[1] ^ raw[0]} + rot;
    point = {q[1], q[1] ^ q[0]};
  end
endmodule : utmsg_tone_mapper

// File: src/utmsg_train_gen.sv
// Purpose: Bits-and-gains encoder plus training and sync symbol tone generator
// Assumes: Item source and tone sink use valid/ready; one clock
// Notes:   Summary of operation below
// Summary of operation
// - Send entries only for used tones
// - Ascending tone order; may stop early
// - Bit count 4 bits, capped at max
// - Gain 12 bits, 3.9 fixed point
// - Pilot request: bits 2, gain 0
// - Groups of equal bits, at most 256
// - Gains only at equidistant sample tones
// - Order from office advertised support
// - Max order k allows 0 to k
// - Descriptor, order octet, then descriptor body
// - Order zero: two octets per tone
// - Odd order: group count, 12-bit carrier count
// - Even order: 8-bit carrier count
// - Training symbols: 4QAM, two octets each
// - Multiples of five zero; others message pairs
// - Rotate each point by random quarter turns
// - Two random bits per tone, DC included
// - Generator runs on; reset at analysis start
// - Sync marker 15 symbols, 11/00/11 pattern
// - Scrambler free-running during sync marker
// - Data mode begins when marker ends
`timescale 1ns/100ps
module utmsg_train_gen #(
  parameter int NUM_TONES = 256
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         chan_analysis_start,
  input  wire logic [3:0]                   max_bits_per_tone,
  input  wire logic [7:0]                   office_max_order,
  input  wire logic                         bg_start,
  input  wire logic [7:0]                   bg_order,
  input  wire logic [15:0]                  bg_group_count,
  output logic                              bg_busy,
  output logic                              bg_error,
  input  wire logic                         item_valid,
  output logic                              item_ready,
  input  wire utmsg_pkg::utmsg_item_s       item,
  output logic      [7:0]                   sample_index,
  output logic      [7:0]                   sample_offset,
  output logic                              oct_valid,
  input  wire logic                         oct_ready,
  output logic      [7:0]                   oct_data,
  output logic                              oct_last,
  input  wire logic                         sym_start,
  input  wire logic [15:0]                  sym_msg,
  input  wire logic                         sync_start,
  input  wire logic [utmsg_pkg::TONE_W-1:0] first_tone,
  input  wire logic [utmsg_pkg::TONE_W-1:0] last_tone,
  output logic                              tone_valid,
  input  wire logic                         tone_ready,
  output utmsg_pkg::utmsg_tone_s            tone,
  output logic                              sym_busy,
  output logic                              sym_done,
  output logic                              scrambler_run,
  output logic                              data_mode_start
);
  typedef enum logic [7:0] {
    E_IDLE  = 8'h01, E_DESC = 8'h02, E_ORDER = 8'h04, E_GCNT  = 8'h08,
    E_TONE  = 8'h10, E_HEAD = 8'h20, E_GAIN  = 8'h40, E_FLUSH = 8'h80
  } utmsg_enc_e;
  typedef enum logic [2:0] {
    Y_IDLE = 3'h1, Y_TRAIN = 3'h2, Y_SYNC = 3'h4
  } utmsg_sym_e;

  localparam logic [utmsg_pkg::TONE_W-1:0] LAST_T = utmsg_pkg::TONE_W'(NUM_TONES - 1);
  localparam logic [3:0] SYNC_N   = 4'(utmsg_pkg::SYNC_SYMS);
  localparam logic [3:0] SEG_LO   = 4'(utmsg_pkg::SYNC_SEG + 1);
  localparam logic [3:0] SEG_HI   = 4'(2 * utmsg_pkg::SYNC_SEG);
  localparam logic [11:0] GRP_MAX = 12'(utmsg_pkg::MAX_GROUP);

  // Clamp a bit load; pilot request forces the fixed pattern
  function automatic logic [3:0] enc_bits(input utmsg_pkg::utmsg_item_s it,
                                          input logic [3:0] bmax);
    if (it.pilot) enc_bits = utmsg_pkg::PILOT_BITS;
    else enc_bits = (it.bits > bmax) ? bmax : it.bits;
  endfunction : enc_bits

  // Two generator steps per tone
  function automatic logic [10:0] prbs_step2(input logic [10:0] s);
    logic [10:0] t;
    t = {s[9:0], s[utmsg_pkg::PRBS_TAP_A] ^ s[utmsg_pkg::PRBS_TAP_B]};
    prbs_step2 = {t[9:0], t[utmsg_pkg::PRBS_TAP_A] ^ t[utmsg_pkg::PRBS_TAP_B]};
  endfunction : prbs_step2

  utmsg_enc_e  enc_reg;
  utmsg_enc_e  enc_next;
  logic [7:0]  order_reg;
  logic [15:0] gcnt_reg;
  logic [15:0] grp_reg;
  logic [7:0]  span_reg;
  logic [7:0]  j_reg;
  logic [31:0] acc_reg;
  logic [5:0]  cnt_reg;
  logic        err_reg;
  logic        room;
  logic        take;
  logic        pop;
  logic        push_en;
  logic [15:0] push_val;
  logic [4:0]  push_w;
  logic [5:0]  base;
  logic [3:0]  bits_q;
  logic [15:0] prod;

  assign room       = (cnt_reg <= 6'h10);
  assign pop        = oct_valid && oct_ready;
  assign oct_valid  = (cnt_reg >= 6'h08);
  assign oct_data   = acc_reg[7:0];
  assign oct_last   = oct_valid && (cnt_reg == 6'h08) && (enc_reg == E_FLUSH);
  assign item_ready = room && (enc_reg inside {E_TONE, E_HEAD, E_GAIN});
  assign take       = item_valid && item_ready;
  assign bg_busy    = (enc_reg != E_IDLE);
  assign bg_error   = err_reg;
  assign bits_q     = enc_bits(item, max_bits_per_tone);
  assign sample_index = j_reg;
  assign prod       = j_reg * span_reg;
  // Equidistant sample tone, offset from the group's lowest tone
  assign sample_offset = (order_reg == 8'h00) ? 8'h00 : 8'(prod / order_reg);

  // Field to push and next state of the encoder
  always_comb begin
    enc_next = enc_reg;
    push_en  = 1'b0;
    push_val = 16'h0000;
    push_w   = utmsg_pkg::W_OCT;
    unique case (enc_reg)
      E_IDLE: begin
        if (bg_start && bg_order <= office_max_order) enc_next = E_DESC;
      end
      E_DESC: begin
        push_en  = room;
        push_val = {8'h00, utmsg_pkg::BG_DESC};
        if (room) enc_next = E_ORDER;
      end
      E_ORDER: begin
        push_en  = room;
        push_val = {8'h00, order_reg};
        if (room) enc_next = (order_reg == 8'h00) ? E_TONE : E_GCNT;
      end
      E_GCNT: begin
        push_en  = room;
        push_val = gcnt_reg;
        push_w   = utmsg_pkg::W_WORD;
        if (room) enc_next = (gcnt_reg == 16'h0000) ? E_FLUSH : E_HEAD;
      end
      E_TONE: begin
        // Unused tones are dropped; the source may end early on last
        push_en  = take && item.used;
        push_val = {(item.pilot ? utmsg_pkg::PILOT_GAIN : item.gain), bits_q};
        push_w   = utmsg_pkg::W_WORD;
        if (take && item.last) enc_next = E_FLUSH;
      end
      E_HEAD: begin
        if (take && (item.count > GRP_MAX || item.count == 12'h000)) begin
          enc_next = E_IDLE;
        end else if (take) begin
          push_en  = 1'b1;
          if (order_reg[0]) begin
            push_val = {item.count, bits_q};
            push_w   = utmsg_pkg::W_WORD;
          end else begin
            push_val = {4'h0, item.count[7:0], bits_q};
            push_w   = utmsg_pkg::W_GAIN;
          end
          enc_next = E_GAIN;
        end
      end
      E_GAIN: begin
        push_en  = take;
        push_val = {4'h0, item.gain};
        push_w   = utmsg_pkg::W_GAIN;
        if (take && j_reg == order_reg) begin
          enc_next = (grp_reg + 16'h0001 == gcnt_reg) ? E_FLUSH : E_HEAD;
        end
      end
      E_FLUSH: begin
        if (cnt_reg == 6'h08 && pop) enc_next = E_IDLE;
        if (cnt_reg == 6'h00) enc_next = E_IDLE;
      end
    endcase
  end

  // Encoder state and message parameters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_reg   <= E_IDLE;
      order_reg <= 8'h00;
      gcnt_reg  <= 16'h0000;
    end else begin
      enc_reg <= enc_next;
      if (enc_reg == E_IDLE && bg_start) begin
        order_reg <= bg_order;
        gcnt_reg  <= bg_group_count;
      end
    end
  end

  // Group walk: span of the group and sample counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grp_reg  <= 16'h0000;
      span_reg <= 8'h00;
      j_reg    <= 8'h00;
    end else if (enc_reg == E_IDLE) begin
      grp_reg <= 16'h0000;
      j_reg   <= 8'h00;
    end else if (take && enc_reg == E_HEAD) begin
      span_reg <= 8'(item.count - 12'h001);
      j_reg    <= 8'h00;
    end else if (take && enc_reg == E_GAIN) begin
      j_reg <= j_reg + 8'h01;
      if (j_reg == order_reg) grp_reg <= grp_reg + 16'h0001;
    end
  end

  // Refusal pulse for an unsupported order or an oversized or empty group
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= (enc_reg == E_IDLE && bg_start && bg_order > office_max_order) ||
                 (enc_reg == E_HEAD && take &&
                  (item.count > GRP_MAX || item.count == 12'h000));
    end
  end

  // Octet packer, LSB first; fields never straddle a message end
  always_comb begin
    base = pop ? cnt_reg - 6'h08 : cnt_reg;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else begin
      acc_reg <= (pop ? {8'h00, acc_reg[31:8]} : acc_reg) |
                 (push_en ? ({16'h0000, push_val} << base) : 32'h0000_0000);
      cnt_reg <= base + (push_en ? {1'b0, push_w} : 6'h00);
    end
  end

  // ---- Training and sync symbol generation ----
  utmsg_sym_e                   sym_reg;
  logic [utmsg_pkg::TONE_W-1:0] tcnt_reg;
  logic [3:0]                   scnt_reg;
  logic [15:0]                  msg_reg;
  logic [10:0]                  prbs_reg;
  logic                         tvalid_reg;
  utmsg_pkg::utmsg_tone_s       tone_reg;
  logic                         done_reg;
  logic                         dmode_reg;
  logic                         load;
  logic                         sym_end;
  logic [1:0]                   map_raw;
  logic [1:0]                   map_point;
  logic [1:0]                   sync_pt;
  logic [10:0]                  prbs_nx;

  assign load       = (sym_reg != Y_IDLE) && (!tvalid_reg || tone_ready);
  assign sym_end    = load && (tcnt_reg == LAST_T);
  assign tone_valid = tvalid_reg;
  assign tone       = tone_reg;
  assign sym_busy   = (sym_reg != Y_IDLE);
  assign sym_done   = done_reg;
  assign data_mode_start = dmode_reg;
  assign scrambler_run   = 1'b1;
  assign prbs_nx         = prbs_step2(prbs_reg);
  // Middle five symbols use 00, outer ten use 11
  assign sync_pt = (scnt_reg >= SEG_LO && scnt_reg <= SEG_HI) ?
                   utmsg_pkg::PT_ZERO : utmsg_pkg::PT_ONE;

  utmsg_tone_mapper utmsg_tone_mapper_i (
    .tone_idx   (tcnt_reg),
    .sync_mode  (sym_reg == Y_SYNC),
    .sync_point (sync_pt),
    .msg        (msg_reg),
    .rot        (prbs_nx[1:0]),
    .raw        (map_raw),
    .point      (map_point)
  );

  // Symbol sequencing; new starts are ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sym_reg  <= Y_IDLE;
      tcnt_reg <= '0;
      scnt_reg <= 4'h0;
      msg_reg  <= 16'h0000;
    end else if (sym_reg == Y_IDLE) begin
      tcnt_reg <= '0;
      scnt_reg <= 4'h1;
      if (sync_start) begin
        sym_reg <= Y_SYNC;
      end else if (sym_start) begin
        sym_reg <= Y_TRAIN;
        msg_reg <= sym_msg;
      end
    end else if (load) begin
      tcnt_reg <= sym_end ? '0 : tcnt_reg + 1'b1;
      if (sym_end && sym_reg == Y_TRAIN) sym_reg <= Y_IDLE;
      if (sym_end && sym_reg == Y_SYNC) begin
        scnt_reg <= scnt_reg + 4'h1;
        if (scnt_reg == SYNC_N) sym_reg <= Y_IDLE;
      end
    end
  end

  // Rotation source: steps per tone, never restarted by symbols
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prbs_reg <= utmsg_pkg::PRBS_SEED;
    end else if (chan_analysis_start) begin
      prbs_reg <= utmsg_pkg::PRBS_SEED;
    end else if (load) begin
      prbs_reg <= prbs_nx;
    end
  end

  // Tone output register; DC and unallowed tones still emitted inactive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tvalid_reg <= 1'b0;
      tone_reg   <= '0;
    end else if (load) begin
      tvalid_reg      <= 1'b1;
      tone_reg.idx    <= tcnt_reg;
      tone_reg.raw    <= map_raw;
      tone_reg.point  <= map_point;
      tone_reg.active <= (tcnt_reg >= first_tone) && (tcnt_reg <= last_tone);
    end else if (tone_ready) begin
      tvalid_reg <= 1'b0;
    end
  end

  // End pulses; data mode opens as the marker's last tone is issued
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg  <= 1'b0;
      dmode_reg <= 1'b0;
    end else begin
      done_reg  <= sym_end;
      dmode_reg <= sym_end && sym_reg == Y_SYNC && scnt_reg == SYNC_N;
    end
  end

  // ---- Checks ----
  sequence s_marker_end;
    sym_end && sym_reg == Y_SYNC && scnt_reg == SYNC_N;
  endsequence
  sequence s_mode_pulse;
    dmode_reg ##1 !dmode_reg;
  endsequence

  a_unused_dropped: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_TONE && take && !item.used) |-> !push_en)
    else $error("unused tone entry was sent");
  a_bits_capped: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_TONE && take && !item.pilot) |-> bits_q <= max_bits_per_tone)
    else $error("bit count above maximum");
  a_pilot_code: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_TONE && take && item.pilot && item.used) |->
      push_val == {utmsg_pkg::PILOT_GAIN, utmsg_pkg::PILOT_BITS})
    else $error("pilot request not coded as 2 and zero gain");
  a_group_limit: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_HEAD && take && item.count > GRP_MAX) |=> bg_error && enc_reg == E_IDLE)
    else $error("oversized group not refused");
  a_order_refused: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_IDLE && bg_start && bg_order > office_max_order) |=>
      bg_error && !bg_busy)
    else $error("unsupported order accepted");
  a_last_sample: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_GAIN && j_reg == order_reg) |-> sample_offset == span_reg)
    else $error("last sample tone not at group top");
  a_header_first: assert property (@(posedge clk) disable iff (rst)
    (enc_reg == E_IDLE && enc_next == E_DESC) |=> ##1 cnt_reg == 6'h08 &&
      acc_reg[7:0] == utmsg_pkg::BG_DESC)
    else $error("descriptor octet not first");
  a_dead_tone: assert property (@(posedge clk) disable iff (rst)
    (load && sym_reg == Y_TRAIN && (tcnt_reg % utmsg_pkg::DEAD_STEP) == 0) |=>
      tone_reg.raw == utmsg_pkg::PT_ZERO)
    else $error("multiple of five tone not at 00");
  a_prbs_per_tone: assert property (@(posedge clk) disable iff (rst)
    (load && !chan_analysis_start) |=> prbs_reg == prbs_step2($past(prbs_reg)))
    else $error("generator did not advance two bits");
  a_sync_middle: assert property (@(posedge clk) disable iff (rst)
    (load && sym_reg == Y_SYNC && scnt_reg >= SEG_LO && scnt_reg <= SEG_HI) |=>
      tone_reg.raw == utmsg_pkg::PT_ZERO)
    else $error("middle sync symbols not at 00");
  a_marker_end: assert property (@(posedge clk) disable iff (rst)
    s_marker_end |=> (sym_reg == Y_IDLE) ##0 s_mode_pulse)
    else $error("data mode not entered at marker end");
  a_scrambler_on: assert property (@(posedge clk) disable iff (rst)
    (sym_reg == Y_SYNC) |-> scrambler_run)
    else $error("scrambler paused during sync marker");
endmodule : utmsg_train_gen

// File: verif/utmsg_office_model.sv
// Purpose: Office-side receiver of octets and tones
// Assumes: Ready lines change just after the rising edge
// Notes:   Slow mode takes one transfer in three
`timescale 1ns/100ps
module utmsg_office_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic oct_valid,
  input  wire logic oct_last,
  output logic      oct_ready,
  input  wire logic tone_valid,
  output logic      tone_ready,
  output logic      msg_closed
);
  logic [1:0] stall_reg;

  // Stall phase counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stall_reg <= 2'h0;
    end else begin
      stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
    end
  end

  // Ready may drop in mid-stream, like a busy receiver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oct_ready  <= 1'b0;
      tone_ready <= 1'b0;
    end else begin
      oct_ready  <= !slow || (stall_reg == 2'h1);
      tone_ready <= !slow || (stall_reg == 2'h2);
    end
  end

  // Tones after the closing octet are taken as zero-bit tones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_closed <= 1'b0;
    end else if (oct_valid && oct_ready) begin
      msg_closed <= oct_last;
    end
  end
endmodule : utmsg_office_model

// File: verif/utmsg_train_gen_bench.sv
// Purpose: Self-checking bench for the training generator
// Assumes: Office model drives both ready lines
// Notes:   Inputs change at the falling edge; tone count cut to 20
`timescale 1ns/100ps
module utmsg_train_gen_bench;
  localparam int NT = 20;
  logic        clk, rst, chan_analysis_start, bg_start, bg_busy, bg_error, item_valid;
  logic        item_ready, oct_valid, oct_ready, oct_last, sym_start, sync_start, tone_valid;
  logic        tone_ready, sym_busy, sym_done, scrambler_run, data_mode_start, slow, closed;
  logic [3:0]  max_bits_per_tone;
  logic [7:0]  office_max_order, bg_order, sample_index, sample_offset, oct_data;
  logic [15:0] bg_group_count, sym_msg;
  logic [11:0] first_tone, last_tone;
  logic [8:0]  got_q[$], exp_q[$];
  logic [39:0] pts, pts_a, pts_b;
  int          error_cnt, samples_checked, dm_cnt, dm_at, dn_cnt;
  utmsg_pkg::utmsg_item_s item, it_q[$];
  utmsg_pkg::utmsg_tone_s tone, tn_q[$];

  utmsg_train_gen #(.NUM_TONES(NT)) utmsg_train_gen_i (
    .clk, .rst, .chan_analysis_start, .max_bits_per_tone, .office_max_order, .bg_start,
    .bg_order, .bg_group_count, .bg_busy, .bg_error, .item_valid, .item_ready, .item,
    .sample_index, .sample_offset, .oct_valid, .oct_ready, .oct_data, .oct_last, .sym_start,
    .sym_msg, .sync_start, .first_tone, .last_tone, .tone_valid, .tone_ready, .tone,
    .sym_busy, .sym_done, .scrambler_run, .data_mode_start);
  utmsg_office_model utmsg_office_model_i (.clk, .rst, .slow, .oct_valid, .oct_last,
    .oct_ready, .tone_valid, .tone_ready, .msg_closed(closed));

  // Clock of 50 ns
  always #25 clk = ~clk;

  // Record accepted transfers at the falling edge, where both sides are settled
  always @(negedge clk) begin
    if (oct_valid === 1'b1 && oct_ready === 1'b1) got_q.push_back({oct_last, oct_data});
    if (tone_valid === 1'b1 && tone_ready === 1'b1) tn_q.push_back(tone);
    if (sym_done === 1'b1) dn_cnt++;
    if (data_mode_start === 1'b1) begin
      dm_cnt++;
      dm_at = tn_q.size();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic hang(input int n, input string what);
    if (n >= 900) begin
      error_cnt++;
      $display("[FAIL] %s expected done seen timeout", what);
      print_verdict();
    end
  endtask : hang

  function automatic utmsg_pkg::utmsg_item_s mk(input logic [2:0] f, input logic [3:0] b,
                                                input logic [11:0] g, input logic [11:0] c);
    return {f, b, g, c};
  endfunction : mk

  task automatic start_msg(input logic [7:0] ord, input logic [15:0] gc);
    got_q.delete();
    bg_order = ord;
    bg_group_count = gc;
    bg_start = 1'b1;
    @(negedge clk);
    bg_start = 1'b0;
  endtask : start_msg

  // Sends the item queue and compares every octet with its last flag
  task automatic send_msg(input logic [7:0] ord, input logic [15:0] gc, input int span);
    int   n;
    int   j;
    logic ok;
    j = 0;
    start_msg(ord, gc);
    chk("bg_busy", 16'h1, {15'h0, bg_busy});
    foreach (it_q[i]) begin
      item = it_q[i];
      item_valid = 1'b1;
      for (n = 0; n < 900; n++) begin
        #5;
        ok = (item_ready === 1'b1);
        if (ok && ord != 8'h0 && it_q[i].count == 12'h0) begin
          chk("sample_index", 16'(j), {8'h0, sample_index});
          chk("sample_offset", 16'(j * span / int'(ord)), {8'h0, sample_offset});
          j++;
        end else if (ok) begin
          j = 0;
        end
        @(negedge clk);
        if (ok) break;
      end
      hang(n, "item");
    end
    item_valid = 1'b0;
    for (n = 0; n < 900 && bg_busy !== 1'b0; n++) @(negedge clk);
    hang(n, "bg_busy");
    repeat (4) @(negedge clk);
    chk("octet count", 16'(exp_q.size()), 16'(got_q.size()));
    foreach (exp_q[i]) chk("octet", {7'h0, exp_q[i]}, {7'h0, got_q[i]});
    $display("message order %0h done", ord);
  endtask : send_msg

  // A refused order or group head gives one error pulse and never a closing octet
  task automatic refuse(input logic [7:0] ord, input logic [11:0] cnt);
    int hits;
    hits = 0;
    start_msg(ord, 16'h1);
    item = mk(3'h4, 4'h1, 12'h0, cnt);
    item_valid = 1'b1;
    repeat (8) begin
      hits += int'(bg_error === 1'b1);
      @(negedge clk);
    end
    item_valid = 1'b0;
    chk("bg_error pulses", 16'h1, 16'(hits));
    chk("bg_busy after refusal", 16'h0, {15'h0, bg_busy});
    foreach (got_q[i]) chk("closing octet", 16'h0, {15'h0, got_q[i][8]});
    $display("refusal done");
  endtask : refuse

  // One training symbol or the sync marker; checks index, raw point and range flag
  task automatic run_sym(input logic sync, input logic [15:0] msg);
    int         n;
    int         k;
    logic [1:0] raw;
    tn_q.delete();
    dm_cnt = 0;
    dn_cnt = 0;
    sym_msg = msg;
    sync_start = sync;
    sym_start = 1'b1;
    @(negedge clk);
    sync_start = 1'b0;
    sym_start = 1'b0;
    for (n = 0; n < 900 && sym_busy !== 1'b0; n++) @(negedge clk);
    hang(n, "sym_busy");
    repeat (3) @(negedge clk);
    chk("tone count", 16'(sync ? 15 * NT : NT), 16'(tn_q.size()));
    chk("sym_done pulses", 16'(sync ? 15 : 1), 16'(dn_cnt));
    foreach (tn_q[i]) begin
      k = (i % 10 < 5) ? 2 * (i % 10) - 2 : 2 * (i % 10) - 4;
      raw = (i % 5 == 0) ? 2'h0 : {msg[k + 1], msg[k]};
      if (sync) raw = (i / NT >= 5 && i / NT <= 9) ? 2'h0 : 2'h3;
      chk("tone idx", 16'(i % NT), 16'(tn_q[i].idx));
      chk("tone raw", {14'h0, raw}, {14'h0, tn_q[i].raw});
      chk("tone active", 16'(i % NT >= 1 && i % NT <= NT - 2), {15'h0, tn_q[i].active});
      if (i < NT) pts[2 * i +: 2] = tn_q[i].point;
    end
    $display("symbol run done");
  endtask : run_sym

  task automatic restart_rotation();
    chan_analysis_start = 1'b1;
    @(negedge clk);
    chan_analysis_start = 1'b0;
  endtask : restart_rotation

  // Main sequence
  initial begin
    {clk, chan_analysis_start, bg_start, item_valid, sym_start, sync_start, slow} = '0;
    rst = 1'b1;
    max_bits_per_tone = 4'ha;
    office_max_order = 8'h1;
    {bg_order, bg_group_count, sym_msg, item} = '0;
    first_tone = 12'h001;
    last_tone = 12'h012;
    {error_cnt, samples_checked, dm_cnt, dm_at, dn_cnt} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("idle", 16'h1, {14'h0, bg_busy, scrambler_run});
    it_q = '{mk(3'h4, 4'h3, 12'h280, 12'h0), mk(3'h0, 4'h7, 12'hfff, 12'h0),
             mk(3'h4, 4'hf, 12'h5a5, 12'h0), mk(3'h7, 4'h9, 12'h777, 12'h0)};
    exp_q = '{{1'b0, utmsg_pkg::BG_DESC}, 9'h000, 9'h003, 9'h028, 9'h05a, 9'h05a, 9'h002, 9'h100};
    send_msg(8'h0, 16'h0, 0);
    chk("receiver closed", 16'h1, {15'h0, closed});
    chk("gain entry", 16'h2803, {got_q[3][7:0], got_q[2][7:0]});
    chk("pilot entry", 16'h0002, {got_q[7][7:0], got_q[6][7:0]});
    refuse(8'h2, 12'h010);
    it_q = '{mk(3'h4, 4'h5, 12'h0, 12'h010), mk(3'h4, 4'h0, 12'habc, 12'h0),
             mk(3'h5, 4'h0, 12'h123, 12'h0)};
    exp_q = '{{1'b0, utmsg_pkg::BG_DESC}, 9'h001, 9'h001, 9'h000, 9'h005, 9'h001, 9'h0bc,
              9'h03a, 9'h112};
    send_msg(8'h1, 16'h1, 15);
    office_max_order = 8'h2;
    it_q = '{mk(3'h4, 4'h3, 12'h0, 12'h100), mk(3'h4, 4'h0, 12'h111, 12'h0),
             mk(3'h4, 4'h0, 12'h222, 12'h0), mk(3'h5, 4'h0, 12'h333, 12'h0)};
    exp_q = '{{1'b0, utmsg_pkg::BG_DESC}, 9'h002, 9'h001, 9'h000, 9'h003, 9'h010, 9'h011,
              9'h022, 9'h032, 9'h133};
    send_msg(8'h2, 16'h1, 255);
    refuse(8'h1, 12'h101);
    refuse(8'h1, 12'h000);
    restart_rotation();
    run_sym(1'b0, 16'hb4e1);
    pts_a = pts;
    slow = 1'b1;
    run_sym(1'b0, 16'hb4e1);
    pts_b = pts;
    slow = 1'b0;
    restart_rotation();
    run_sym(1'b0, 16'hb4e1);
    chk("rotation restart", 16'h1, 16'(pts === pts_a));
    chk("rotation continues", 16'h1, 16'(pts_b !== pts_a));
    run_sym(1'b1, 16'h0);
    chk("data mode pulses", 16'h1, 16'(dm_cnt));
    chk("data mode point", 16'(15 * NT), 16'(dm_at));
    chk("scrambler_run", 16'h1, {15'h0, scrambler_run});
    print_verdict();
  end
endmodule : utmsg_train_gen_bench
